// *** src/rec_engine.sv ***
// Record parser and responder for the flash rewrite byte link
module rec_engine #(
  parameter int MAX_PAYLOAD = rec_pkg::DATA_MAX_PAYLOAD
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic backup_enable_in,
  output logic erase_req_out,
  output logic [31:0] erase_start_out,
  output logic [31:0] erase_end_out,
  input wire logic erase_done_in,
  input wire logic [7:0] erase_code_in,
  output logic wr_valid_out,
  output logic [31:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  input wire logic wr_ready_in,
  input wire logic [7:0] wr_code_in,
  output logic session_out
);
  typedef enum logic [3:0] {
    ST_TYPE, ST_LEN, ST_BODY, ST_SUM, ST_ACT_ERASE, ST_WAIT_ERASE,
    ST_ACT_WRITE, ST_RESP, ST_DRAIN
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [7:0] rtype;
    logic [7:0] len;
    logic [6:0] idx;
    logic [31:0] addr0;
    logic [31:0] addr1;
    logic [7:0] body_bad;
    logic [6:0] wcount;
    logic [7:0] resp_type;
    logic [7:0] resp_code;
    logic [2:0] tx_idx;
    logic erase_req;
    logic [31:0] erase_start;
    logic [31:0] erase_end;
    logic wr_valid;
    logic [31:0] wr_addr;
    logic [7:0] wr_data;
    logic session;
  } state_s;

  state_s state;
  state_s next_state;
  logic [7:0] payload [0:63];
  logic store_pay;
  logic [5:0] store_idx;
  logic rx_take;
  rec_pkg::byte_s rx_b;
  logic buf_ready;
  logic sum_clear;
  logic sum_add;
  logic [7:0] sum_byte;
  logic [7:0] sum_val;
  logic [7:0] tx_byte;
  logic tx_push;
  logic tx_buf_ready;

  // Refuse a payload limit the record format and memory cannot serve
  if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > 57) begin : g_bad_payload
    $error("rec_engine: MAX_PAYLOAD out of range");
  end

  // Put a little-endian byte into a 32-bit address
  function automatic logic [31:0] le_put(input logic [31:0] a, input logic [1:0] i,
                                         input logic [7:0] b);
    logic [31:0] r;
    r = a;
    r[8*i +: 8] = b;
    return r;
  endfunction

  // Inbound bytes pass through the two-entry buffer
  rec_buf #(.WIDTH(8)) rx_buf (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(rx_valid_in),
    .in_data_in(rx_data_in),
    .in_ready_out(buf_ready),
    .out_valid_out(rx_b.valid),
    .out_data_out(rx_b.data),
    .out_ready_in(rx_take)
  );

  rec_sum sum_unit (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .clear_in(sum_clear),
    .add_in(sum_add),
    .byte_in(sum_byte),
    .sum_out(sum_val),
    .zero_out()
  );

  // Response byte sequence, five bytes
  always_comb begin
    case (state.tx_idx)
      3'd0: tx_byte = rec_pkg::TYPE_RESP;
      3'd1: tx_byte = rec_pkg::RESP_LEN_BYTE;
      3'd2: tx_byte = state.resp_type;
      3'd3: tx_byte = state.resp_code;
      default: tx_byte = 8'(-(rec_pkg::RESP_LEN_BYTE + state.resp_type + state.resp_code));
    endcase
  end

  // Receive phases take a byte only when the buffer holds one
  assign rx_take = rx_b.valid && (state.phase == ST_TYPE || state.phase == ST_LEN ||
                   state.phase == ST_BODY || state.phase == ST_SUM || state.phase == ST_DRAIN);
  assign sum_clear = rx_take && state.phase == ST_TYPE;
  assign sum_add = rx_take && state.phase != ST_TYPE && state.phase != ST_DRAIN;
  assign sum_byte = rx_b.data;
  assign tx_push = state.phase == ST_RESP && tx_buf_ready;
  assign store_pay = rx_take && state.phase == ST_BODY && state.rtype == rec_pkg::TYPE_DATA &&
                     state.idx >= 7'd4 && state.idx < 7'd61;
  assign store_idx = 6'(state.idx - 7'd4);

  // Payload memory for one data record
  always_ff @(posedge clock_in) begin
    if (store_pay) begin
      payload[store_idx] <= rx_b.data;
    end
  end

  // Protocol sequencing
  always_comb begin
    next_state = state;
    next_state.erase_req = 1'b0;
    case (state.phase)
      ST_TYPE: begin
        if (rx_take) begin
          next_state.rtype = rx_b.data;
          next_state.idx = 7'd0;
          next_state.body_bad = 8'h00;
          next_state.phase = ST_LEN;
        end
      end
      ST_LEN: begin
        if (rx_take) begin
          next_state.len = rx_b.data;
          next_state.phase = ST_BODY;
          case (state.rtype)
            rec_pkg::TYPE_START: begin
              if (rx_b.data != rec_pkg::START_LEN_BYTE) next_state.body_bad = rec_pkg::ERR_PARAM;
            end
            rec_pkg::TYPE_DATA: begin
              // Length counts payload plus checksum after the load address
              if (rx_b.data < 8'h02 || rx_b.data > 8'(MAX_PAYLOAD + 1)) begin
                next_state.body_bad = rec_pkg::ERR_PARAM;
                next_state.phase = ST_DRAIN;
              end
            end
            rec_pkg::TYPE_END: begin
              if (rx_b.data != rec_pkg::END_LEN_BYTE) next_state.body_bad = rec_pkg::ERR_PARAM;
            end
            default: begin
              next_state.body_bad = 8'hFF;
              next_state.phase = ST_DRAIN;
            end
          endcase
          if (next_state.phase == ST_DRAIN) begin
            next_state.phase = ST_RESP;
            next_state.resp_type = rec_pkg::RESP_ERROR;
            next_state.resp_code = rec_pkg::ERR_PARAM;
            next_state.tx_idx = 3'd0;
          end
        end
      end
      ST_BODY: begin
        if (rx_take) begin
          next_state.idx = state.idx + 7'd1;
          if (state.rtype == rec_pkg::TYPE_START) begin
            if (state.idx >= 7'd2 && state.idx < 7'd6) begin
              next_state.addr0 = le_put(state.addr0, 2'(state.idx - 7'd2), rx_b.data);
            end else if (state.idx >= 7'd6 && state.idx < 7'd10) begin
              next_state.addr1 = le_put(state.addr1, 2'(state.idx - 7'd6), rx_b.data);
            end
            if (state.idx == 7'd10) next_state.phase = ST_SUM;
          end else if (state.rtype == rec_pkg::TYPE_DATA) begin
            if (state.idx < 7'd4) begin
              next_state.addr0 = le_put(state.addr0, 2'(state.idx), rx_b.data);
            end
            if (state.idx == 7'(state.len) + 7'd2) next_state.phase = ST_SUM;
          end else begin
            next_state.phase = ST_SUM;
          end
        end
      end
      ST_SUM: begin
        if (rx_take) begin
          next_state.tx_idx = 3'd0;
          next_state.phase = ST_RESP;
          if (8'(sum_val + rx_b.data) != 8'h00) begin
            next_state.resp_type = rec_pkg::RESP_RETRY;
            next_state.resp_code = rec_pkg::ERR_PARAM;
          end else if (state.body_bad != 8'h00) begin
            next_state.resp_type = rec_pkg::RESP_ERROR;
            next_state.resp_code = state.body_bad;
          end else if (state.rtype == rec_pkg::TYPE_START) begin
            next_state.erase_req = 1'b1;
            next_state.erase_start = state.addr0;
            next_state.erase_end = state.addr1;
            next_state.session = 1'b1;
            next_state.phase = ST_WAIT_ERASE;
          end else if (state.rtype == rec_pkg::TYPE_DATA) begin
            next_state.wcount = 7'd0;
            next_state.phase = ST_ACT_WRITE;
          end else begin
            next_state.resp_type = rec_pkg::RESP_ACK;
            next_state.resp_code = rec_pkg::STAT_WRITING;
            next_state.session = 1'b0;
          end
        end
      end
      ST_WAIT_ERASE: begin
        if (erase_done_in) begin
          next_state.phase = ST_RESP;
          if (erase_code_in != 8'h00) begin
            next_state.resp_type = rec_pkg::RESP_ERROR;
            next_state.resp_code = erase_code_in;
          end else begin
            next_state.resp_type = rec_pkg::RESP_ACK;
            next_state.resp_code = backup_enable_in ? rec_pkg::CODE_BACKUP_ON :
                                   rec_pkg::CODE_BACKUP_OFF;
          end
        end
      end
      ST_ACT_WRITE: begin
        if (!state.wr_valid || wr_ready_in) begin
          if (state.wr_valid && wr_code_in != 8'h00) begin
            next_state.wr_valid = 1'b0;
            next_state.resp_type = rec_pkg::RESP_ERROR;
            next_state.resp_code = wr_code_in;
            next_state.phase = ST_RESP;
          end else if (state.wcount == 7'(state.len) - 7'd1) begin
            next_state.wr_valid = 1'b0;
            next_state.resp_type = rec_pkg::RESP_ACK;
            next_state.resp_code = rec_pkg::STAT_WRITING;
            next_state.phase = ST_RESP;
          end else begin
            next_state.wr_valid = 1'b1;
            next_state.wr_addr = state.addr0 + 32'(state.wcount);
            next_state.wr_data = payload[6'(state.wcount)];
            next_state.wcount = state.wcount + 7'd1;
          end
        end
      end
      ST_RESP: begin
        if (tx_push) begin
          next_state.tx_idx = state.tx_idx + 3'd1;
          if (state.tx_idx == 3'(rec_pkg::RESP_LEN - 1)) next_state.phase = ST_TYPE;
        end
      end
      default: next_state.phase = ST_TYPE;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outbound bytes pass through a second buffer toward the link
  rec_buf #(.WIDTH(8)) tx_buf (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(tx_push),
    .in_data_in(tx_byte),
    .in_ready_out(tx_buf_ready),
    .out_valid_out(tx_valid_out),
    .out_data_out(tx_data_out),
    .out_ready_in(tx_ready_in)
  );

  assign rx_ready_out = buf_ready;
  assign erase_req_out = state.erase_req;
  assign erase_start_out = state.erase_start;
  assign erase_end_out = state.erase_end;
  assign wr_valid_out = state.wr_valid;
  assign wr_addr_out = state.wr_addr;
  assign wr_data_out = state.wr_data;
  assign session_out = state.session;
endmodule // rec_engine

// *** include/rec_pkg.sv ***
// Function
// - Start record type byte is 0x00, then length counting bytes after device type.
// - Start record carries little-endian 32-bit erase start address.
// - Start record then carries little-endian 32-bit erase end address.
// - Start record ends in a checksum the device verifies before acting.
// - Data record type byte is 0x0F, then length counting bytes after address.
// - Data payload is 1 to 57 bytes; record is 7 plus payload, max 64.
// - Payload is written to flash from the little-endian load address.
// - Data length byte equals the count of bytes after the load address.
// - Data record checksum covers length, address and payload; checked first. The code answers an out-of-range length with 0xE4 before reaching the checksum.
// - End record type is 0xF0, then length, device type and checksum.
// - End record checksum covers length and device type; device verifies it.
// - Device answers every record with one 0xFF response of 5 bytes.
// - Response length counts bytes after the response type byte.
// - Response type 0x00 ack, 0x0F retransmit, 0xF0 error end.
// - Start record answer field is 0xB0 backup enabled, 0xB1 disabled.
// - Data or end answer status is 0x01 erasing or 0x03 writing.
// - Failures return one error code 0xE1 to 0xE8 in the field.
// - Response ends with a checksum over length, response type and field.
package rec_pkg;
  localparam logic [7:0] TYPE_START = 8'h00;
  localparam logic [7:0] TYPE_DATA = 8'h0F;
  localparam logic [7:0] TYPE_END = 8'hF0;
  localparam logic [7:0] TYPE_RESP = 8'hFF;
  localparam logic [7:0] RESP_ACK = 8'h00;
  localparam logic [7:0] RESP_RETRY = 8'h0F;
  localparam logic [7:0] RESP_ERROR = 8'hF0;
  localparam logic [7:0] CODE_BACKUP_ON = 8'hB0;
  localparam logic [7:0] CODE_BACKUP_OFF = 8'hB1;
  localparam logic [7:0] STAT_ERASING = 8'h01;
  localparam logic [7:0] STAT_WRITING = 8'h03;
  localparam logic [7:0] ERR_INIT = 8'hE1;
  localparam logic [7:0] ERR_SECURITY = 8'hE2;
  localparam logic [7:0] ERR_ERASE = 8'hE3;
  localparam logic [7:0] ERR_PARAM = 8'hE4;
  localparam logic [7:0] ERR_VERIFY = 8'hE5;
  localparam logic [7:0] ERR_OPTION = 8'hE6;
  localparam logic [7:0] ERR_COPY = 8'hE7;
  localparam logic [7:0] ERR_UNUSED = 8'hE8;
  localparam int START_LEN = 14;
  localparam logic [7:0] START_LEN_BYTE = 8'h0B;
  localparam logic [7:0] END_LEN_BYTE = 8'h01;
  localparam int DATA_MAX_PAYLOAD = 57;
  localparam int DATA_OVERHEAD = 7;
  localparam int RESP_LEN = 5;
  localparam logic [7:0] RESP_LEN_BYTE = 8'h02;
  localparam int ADDR_LSB = 0;

  // One byte with its valid flag
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_s;

  // One flash write request
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] data;
  } wr_s;
endpackage

// *** src/rec_sum.sv ***
// Running modulo-256 sum with reset-to-zero
module rec_sum (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clear_in,
  input wire logic add_in,
  input wire logic [7:0] byte_in,
  output logic [7:0] sum_out,
  output logic zero_out
);
  typedef struct packed {
    logic [7:0] sum;
  } state_s;
  state_s state;
  state_s next_state;

  // Accumulate covered bytes
  always_comb begin
    next_state = state;
    if (clear_in) begin
      next_state.sum = 8'h00;
    end else if (add_in) begin
      next_state.sum = state.sum + byte_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sum_out = state.sum;
  assign zero_out = (state.sum == 8'h00);
endmodule // rec_sum

// *** src/rec_buf.sv ***
// Two-entry skid buffer with valid and ready on both sides
module rec_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] count;
  } state_s;
  state_s state;
  state_s next_state;
  logic push;
  logic pop;

  // Refuse a width the storage cannot hold
  if (WIDTH < 1) begin : g_bad_width
    $error("rec_buf: WIDTH must be positive");
  end

  assign push = in_valid_in && (state.count != 2'd2);
  assign pop = state.count != 2'd0 && out_ready_in;

  // Pointer and count update
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr] = in_data_in;
      next_state.wr = ~state.wr;
    end
    if (pop) begin
      next_state.rd = ~state.rd;
    end
    next_state.count = state.count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign in_ready_out = state.count != 2'd2;
  assign out_valid_out = state.count != 2'd0;
  assign out_data_out = state.mem[state.rd];
endmodule // rec_buf

// *** dv/rec_engine_assertions.sv ***
module rec_engine_checker #(
  parameter int MAX_PAYLOAD = 57
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic erase_req_out,
  input wire logic wr_valid_out,
  input wire logic [31:0] wr_addr_out,
  input wire logic [7:0] wr_data_out,
  input wire logic wr_ready_in
);
  logic [2:0] idx;
  logic [7:0] sum;
  logic is_ack;
  wire beat = tx_valid_out && tx_ready_in;

  // Position in the five-byte answer and running sum of its covered bytes
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idx <= 3'h0;
      sum <= 8'h00;
      is_ack <= 1'b0;
    end else if (beat) begin
      idx <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
      if (idx == 3'h2) is_ack <= (tx_data_out == 8'h00);
      sum <= (idx == 3'h0) ? 8'h00 : sum + tx_data_out;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  // The field byte of an answer whose type byte was acknowledge
  sequence field_beat;
    beat && idx == 3'h3;
  endsequence
  sequence ack_field;
    field_beat ##0 is_ack;
  endsequence

  resp_head_a: assert property (tx_valid_out && idx == 3'h0 |-> tx_data_out == 8'hFF)
    else $error("answer does not open with FF");
  resp_len_a: assert property (tx_valid_out && idx == 3'h1 |-> tx_data_out == 8'h02)
    else $error("answer length byte wrong");
  resp_kind_a: assert property (tx_valid_out && idx == 3'h2 |-> tx_data_out inside {8'h00, 8'h0F, 8'hF0})
    else $error("answer type byte unknown");
  field_code_a: assert property (tx_valid_out && idx == 3'h3 |-> tx_data_out inside {8'hB0, 8'hB1, 8'h01, 8'h03, [8'hE1:8'hE8]})
    else $error("answer field code unknown");
  ack_field_a: assert property (ack_field |-> tx_data_out inside {8'hB0, 8'hB1, 8'h01, 8'h03})
    else $error("acknowledge carries an error code");
  resp_sum_a: assert property (tx_valid_out && idx == 3'h4 |-> 8'(sum + tx_data_out) == 8'h00)
    else $error("answer checksum wrong");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("answer byte dropped or changed while stalled");
  wr_hold_a: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable({wr_addr_out, wr_data_out}))
    else $error("flash write changed while stalled");
  erase_pulse_a: assert property ($rose(erase_req_out) |=> !erase_req_out)
    else $error("erase request longer than one cycle");
endmodule // rec_engine_checker

bind rec_engine rec_engine_checker #(.MAX_PAYLOAD(MAX_PAYLOAD)) rec_engine_checker_inst (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .tx_valid_out(tx_valid_out),
  .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in), .erase_req_out(erase_req_out),
  .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
  .wr_ready_in(wr_ready_in)
);

// *** dv/host_model.sv ***
module host_model (
  input wire logic clock_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  logic [1:0] stall_cnt = 2'h0;
  logic [7:0] resp_q[$];

  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b0;
  end

  // Send one whole record; the caller waits for the answer before the next
  task automatic send(input logic [7:0] rec[$]);
    foreach (rec[i]) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= rec[i];
      @(posedge clock_in iff rx_ready_in);
    end
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rec[rec.size() - 1];
  endtask

  // Collect answer bytes, stalling two cycles in four when slow
  always @(posedge clock_in) begin
    stall_cnt <= stall_cnt + 2'h1;
    tx_ready_out <= !slow || stall_cnt[1];
    if (tx_valid_in && tx_ready_out)
      resp_q.push_back(tx_data_in);
  end
endmodule // host_model

// *** dv/tb.sv ***
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, erase_req, wr_valid, session;
  logic [7:0] rx_data, tx_data, wr_data;
  logic [31:0] erase_start, erase_end, wr_addr;
  logic backup_enable = 1'b0;
  logic erase_done = 1'b0;
  logic wr_ready = 1'b0;
  logic wr_stall = 1'b0;
  logic [7:0] erase_code = 8'h00;
  logic [7:0] wr_code = 8'h00;
  logic [39:0] wq[$];
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  rec_engine rec_engine_inst (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_ready_out(rx_ready), .tx_valid_out(tx_valid),
    .tx_data_out(tx_data), .tx_ready_in(tx_ready), .backup_enable_in(backup_enable),
    .erase_req_out(erase_req), .erase_start_out(erase_start), .erase_end_out(erase_end),
    .erase_done_in(erase_done), .erase_code_in(erase_code), .wr_valid_out(wr_valid),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_ready_in(wr_ready),
    .wr_code_in(wr_code), .session_out(session)
  );

  host_model host_model_inst (
    .clock_in(clock_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .tx_ready_out(tx_ready)
  );

  initial begin
    forever #2 clock_in = ~clock_in;
  end

  // Flash side: erase ends a cycle after the request, writes stall on demand, run is bounded
  always @(posedge clock_in) begin
    erase_done <= erase_req;
    wr_ready <= !wr_stall || !wr_ready;
    if (wr_valid && wr_ready)
      wq.push_back({wr_addr, wr_data});
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR run exceeded its cycle limit");
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Append the two's complement of the sum of all bytes after the type byte
  task automatic seal(ref logic [7:0] q[$]);
    logic [7:0] s = 8'h00;
    foreach (q[i]) if (i > 0) s += q[i];
    q.push_back(8'h00 - s);
  endtask

  task automatic start_rec(input logic [31:0] s, input logic [31:0] e, output logic [7:0] q[$]);
    q = {rec_pkg::TYPE_START, rec_pkg::START_LEN_BYTE, 8'h00, 8'h00, s[7:0], s[15:8], s[23:16],
      s[31:24], e[7:0], e[15:8], e[23:16], e[31:24], 8'h00};
    seal(q);
  endtask

  task automatic data_rec(input logic [31:0] a, input int n, output logic [7:0] q[$]);
    q = {rec_pkg::TYPE_DATA, 8'(n + 1), a[7:0], a[15:8], a[23:16], a[31:24]};
    for (int i = 0; i < n; i++) q.push_back(8'(i * 3 + 1));
    seal(q);
  endtask

  // Send a record, wait for the whole answer and compare it byte by byte
  task automatic do_rec(input logic [7:0] rec[$], input logic [7:0] typ, input logic [7:0] code);
    logic [7:0] want[5];
    int n = 0;
    want = '{8'hFF, 8'h02, typ, code, 8'h00 - (8'h02 + typ + code)};
    host_model_inst.resp_q.delete();
    host_model_inst.send(rec);
    while (host_model_inst.resp_q.size() < 5 && n < 3000) begin
      @(posedge clock_in);
      n++;
    end
    for (int i = 0; i < 5; i++) `CHK("answer byte", want[i], host_model_inst.resp_q[i])
  endtask

  task automatic t_start();
    logic [7:0] q[$];
    for (int b = 0; b < 2; b++) begin
      backup_enable <= b[0];
      start_rec(32'h0001_2340 + b, 32'hFFFF_0007, q);
      do_rec(q, rec_pkg::RESP_ACK, b ? rec_pkg::CODE_BACKUP_ON : rec_pkg::CODE_BACKUP_OFF);
      `CHK("erase start", 32'h0001_2340 + b, erase_start)
      `CHK("erase end", 32'hFFFF_0007, erase_end)
      `CHK("session open", 1'b1, session)
    end
    $display("test start records done");
  endtask

  task automatic t_data();
    logic [7:0] q[$];
    logic [31:0] a;
    host_model_inst.slow = 1'b1;
    wr_stall <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      a = 32'h0001_3001 + k * 32'h100;
      wq.delete();
      data_rec(a, k ? 57 : 1, q);
      do_rec(q, rec_pkg::RESP_ACK, rec_pkg::STAT_WRITING);
      `CHK("write count", k ? 57 : 1, wq.size())
      foreach (wq[i]) `CHK("flash write", {32'(a + i), q[6 + i]}, wq[i])
    end
    $display("test data records done");
  endtask

  task automatic t_bad_sum();
    logic [7:0] q[$];
    data_rec(32'h0001_4000, 4, q);
    q[q.size() - 1] ^= 8'h5A;
    wq.delete();
    do_rec(q, rec_pkg::RESP_RETRY, rec_pkg::ERR_PARAM);
    `CHK("writes after bad sum", 0, wq.size())
    $display("test bad checksum done");
  endtask

  task automatic t_end();
    logic [7:0] q[$];
    q = {rec_pkg::TYPE_END, rec_pkg::END_LEN_BYTE, 8'h00};
    seal(q);
    do_rec(q, rec_pkg::RESP_ACK, rec_pkg::STAT_WRITING);
    `CHK("session closed", 1'b0, session)
    $display("test end record done");
  endtask

  task automatic t_faults();
    logic [7:0] q[$];
    host_model_inst.slow = 1'b0;
    backup_enable <= 1'b0;
    start_rec(32'h0000_0100, 32'h0000_01FF, q);
    do_rec(q, rec_pkg::RESP_ACK, rec_pkg::CODE_BACKUP_OFF);
    wr_code <= rec_pkg::ERR_VERIFY;
    data_rec(32'h0000_0100, 2, q);
    do_rec(q, rec_pkg::RESP_ERROR, rec_pkg::ERR_VERIFY);
    wr_code <= 8'h00;
    erase_code <= rec_pkg::ERR_ERASE;
    start_rec(32'h0000_0200, 32'h0000_02FF, q);
    do_rec(q, rec_pkg::RESP_ERROR, rec_pkg::ERR_ERASE);
    erase_code <= 8'h00;
    q = {8'h55, 8'h01};
    do_rec(q, rec_pkg::RESP_ERROR, rec_pkg::ERR_PARAM);
    $display("test faults done");
  endtask

  initial begin
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    `CHK("session after reset", 1'b0, session)
    t_start();
    t_data();
    t_bad_sum();
    t_end();
    t_faults();
    complete_run();
  end
endmodule // tb
